// File: mic_core_model.sv
// Behavioural model of the core sequencer facing the controller
`timescale 1ns/100ps
module mic_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controller side
  input wire mic_pkg::mic_core_req_t core_req,
  output logic irq_accept,
  output logic return_from_irq,
  output logic [12:0] return_pc,
  // Bench side
  input wire logic [3:0] lag,
  input wire logic ret_req,
  output logic [12:0] taken_pc,
  output logic [7:0] n_acc
);
  logic [3:0] cnt;
  logic [12:0] pc;
  assign return_pc = pc;
  // Pc runs so every accept pushes a fresh address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {irq_accept, return_from_irq, cnt, pc, taken_pc, n_acc} <= '0;
    end else begin
      pc <= pc + 13'h1;
      irq_accept <= 1'b0;
      return_from_irq <= ret_req;
      cnt <= 4'h0;
      if (irq_accept && core_req.vector_req) begin
        taken_pc <= pc;
      end
      if (core_req.vector_req && !irq_accept) begin
        cnt <= cnt + 4'h1;
        if (cnt >= lag) begin
          irq_accept <= 1'b1;
          n_acc <= n_acc + 8'h1;
        end
      end
    end
  end
endmodule

// File: mic_event_detect.sv
// Edge and change detection for the four interrupt event sources
`timescale 1ns/100ps
`include "mic_regs.svh"

module mic_event_detect (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw sources
  input wire logic ext_irq_pin,
  input wire logic [7:0] second_io_port,
  input wire logic [7:0] timer_zero_count,
  input wire logic adc_done,
  input wire logic ext_edge_select,
  // Detected one-cycle events
  output mic_pkg::mic_events_t events
);

  logic ext_prev;
  logic [3:0] port_prev;
  logic [7:0] tmr_prev;
  logic adc_prev;
  logic primed;

  wire logic ext_rise = ext_irq_pin & ~ext_prev;
  wire logic ext_fall = ~ext_irq_pin & ext_prev;

  // Primed avoids a false event from the first sample after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev <= 1'b0;
      port_prev <= 4'h0;
      tmr_prev <= 8'h00;
      adc_prev <= 1'b0;
      primed <= 1'b0;
      events <= '0;
    end else begin
      ext_prev <= ext_irq_pin;
      port_prev <= second_io_port[7:4];
      tmr_prev <= timer_zero_count;
      adc_prev <= adc_done;
      primed <= 1'b1;
      events.ext_pin <= primed & (ext_edge_select ? ext_rise : ext_fall);
      events.tmr_ovf <= primed & (tmr_prev == 8'hff) & (timer_zero_count == 8'h00);
      events.port_chg <= primed & (port_prev != second_io_port[7:4]);
      events.adc_done <= primed & adc_done & ~adc_prev;
    end
  end

endmodule

// File: mic_irq_asserts.sv
// Concurrent checks on the interrupt controller ports
`timescale 1ns/100ps
`include "mic_regs.svh"
module mic_irq_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side
  input wire logic irq_accept,
  input wire logic return_from_irq,
  input wire logic [12:0] return_pc,
  input wire mic_pkg::mic_core_req_t core_req,
  input wire logic [12:0] saved_pc
);
  logic blocked;
  // Enable is surely clear after reset or accept, until a return or any write
  always_ff @(posedge aclk) begin
    if (!aresetn || (irq_accept && core_req.vector_req)) begin
      blocked <= 1'b1;
    end else if (return_from_irq || s_axi_bvalid) begin
      blocked <= 1'b0;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  vector_addr_fixed_a: assert property (
    core_req.vector_req |-> core_req.vector_addr == `MIC_VECTOR) else $error("bad vector");
  accept_drops_req_a: assert property (
    irq_accept && core_req.vector_req |=> !core_req.vector_req) else $error("req held");
  accept_saves_pc_a: assert property (
    irq_accept && core_req.vector_req |=> saved_pc == $past(return_pc)) else $error("pc lost");
  disabled_no_req_a: assert property (
    blocked |-> !core_req.vector_req) else $error("req while disabled");
  bresp_holds_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  bvalid_refuses_a: assert property (
    s_axi_bvalid |-> !s_axi_awready) else $error("aw taken early");
  rdata_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  unmapped_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h014
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("no slverr");
endmodule
bind mic_irq_ctrl mic_irq_asserts u_chk (.*);

// File: mic_irq_ctrl.sv
// Interrupt controller top: AXI4-Lite registers, flags, vectoring and wake-up
`timescale 1ns/100ps
`include "mic_regs.svh"

module mic_irq_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Event sources
  input wire logic ext_irq_pin,
  input wire logic [7:0] second_io_port,
  input wire logic [7:0] timer_zero_count,
  input wire logic adc_done,
  // Core sequencer
  input wire logic sleep_exec,
  input wire logic irq_accept,
  input wire logic return_from_irq,
  input wire logic [12:0] return_pc,
  output mic_pkg::mic_core_req_t core_req,
  output logic [12:0] saved_pc,
  output logic sleeping
);

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0] interrupt_control_reg;
  logic [7:0] option_reg;
  logic [7:0] periph_flag_reg_one;
  logic [7:0] periph_enable_reg_one;
  logic [12:0] ret_stack [0:7];
  logic [2:0] sp;
  mic_pkg::mic_state_t state;
  mic_pkg::mic_events_t events;

  logic aw_hold, w_hold;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    merge_byte = s[0] ? d[7:0] : old;
  endfunction

  // ****************************************
  // Event detection
  // ****************************************
  mic_event_detect u_detect (
    .aclk(aclk),
    .aresetn(aresetn),
    .ext_irq_pin(ext_irq_pin),
    .second_io_port(second_io_port),
    .timer_zero_count(timer_zero_count),
    .adc_done(adc_done),
    .ext_edge_select(option_reg[`MIC_BIT_EDGE]),
    .events(events)
  );

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
  assign s_axi_bresp = 2'h0;

  wire logic aw_fire = s_axi_awvalid & s_axi_awready;
  wire logic w_fire = s_axi_wvalid & s_axi_wready;
  wire logic have_aw = aw_hold | aw_fire;
  wire logic have_w = w_hold | w_fire;
  wire logic do_write = have_aw & have_w;
  wire logic [11:0] wr_addr = aw_hold ? aw_addr : s_axi_awaddr;
  wire logic [31:0] wr_data = w_hold ? w_data : s_axi_wdata;
  wire logic [3:0] wr_strb = w_hold ? w_strb : s_axi_wstrb;

  wire logic wr_ctrl = do_write & (wr_addr == `MIC_OFF_CTRL);
  wire logic wr_option = do_write & (wr_addr == `MIC_OFF_OPTION);
  wire logic wr_pflag = do_write & (wr_addr == `MIC_OFF_PFLAG1);
  wire logic wr_pen = do_write & (wr_addr == `MIC_OFF_PEN1);
  wire logic wr_known = wr_ctrl | wr_option | wr_pflag | wr_pen | (wr_addr == `MIC_OFF_CORE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else begin
        if (aw_fire) begin
          aw_hold <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_hold <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Control register and flags
  // ****************************************
  wire logic [7:0] ctrl_wr = merge_byte(interrupt_control_reg, wr_data, wr_strb);
  wire logic [7:0] pflag_wr = merge_byte(periph_flag_reg_one, wr_data, wr_strb);

  wire logic ext_pend = interrupt_control_reg[`MIC_BIT_EXT_PIN_FLAG]
                      & interrupt_control_reg[`MIC_BIT_EXT_PIN_ENABLE];
  wire logic tmr_pend = interrupt_control_reg[`MIC_BIT_TIMER_OVERFLOW_FLAG]
                      & interrupt_control_reg[`MIC_BIT_TIMER_OVERFLOW_ENABLE];
  wire logic port_pend = interrupt_control_reg[`MIC_BIT_PORT_CHANGE_FLAG]
                       & interrupt_control_reg[`MIC_BIT_PORT_CHANGE_ENABLE];
  wire logic periph_pend = interrupt_control_reg[`MIC_BIT_PEIE]
                         & |(periph_flag_reg_one & periph_enable_reg_one);
  wire logic any_pend = ext_pend | tmr_pend | port_pend | periph_pend;
  wire logic global_irq_enable = interrupt_control_reg[`MIC_BIT_GIE];

  logic [7:0] next_ctrl;
  logic [7:0] next_pflag;

  always_comb begin
    next_ctrl = wr_ctrl ? ctrl_wr : interrupt_control_reg;
    // Set after the write so a same-cycle clear never drops an event
    next_ctrl[`MIC_BIT_EXT_PIN_FLAG] = next_ctrl[`MIC_BIT_EXT_PIN_FLAG] | events.ext_pin;
    next_ctrl[`MIC_BIT_TIMER_OVERFLOW_FLAG] = next_ctrl[`MIC_BIT_TIMER_OVERFLOW_FLAG] | events.tmr_ovf;
    next_ctrl[`MIC_BIT_PORT_CHANGE_FLAG] = next_ctrl[`MIC_BIT_PORT_CHANGE_FLAG] | events.port_chg;
    if (irq_accept && state == mic_pkg::MIC_VECTOR_WAIT) begin
      next_ctrl[`MIC_BIT_GIE] = 1'b0;
    end else if (return_from_irq) begin
      next_ctrl[`MIC_BIT_GIE] = 1'b1;
    end
    next_pflag = wr_pflag ? pflag_wr : periph_flag_reg_one;
    next_pflag[`MIC_BIT_ADIF] = next_pflag[`MIC_BIT_ADIF] | events.adc_done;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_control_reg <= `MIC_RST_CTRL;
      option_reg <= `MIC_RST_OPTION;
      periph_flag_reg_one <= `MIC_RST_PERIPH;
      periph_enable_reg_one <= `MIC_RST_PERIPH;
    end else begin
      interrupt_control_reg <= next_ctrl;
      periph_flag_reg_one <= next_pflag;
      if (wr_option) begin
        option_reg <= merge_byte(option_reg, wr_data, wr_strb);
      end
      if (wr_pen) begin
        periph_enable_reg_one <= merge_byte(periph_enable_reg_one, wr_data, wr_strb);
      end
    end
  end

  // ****************************************
  // Vectoring, return stack and sleep
  // ****************************************
  // Only the return address is kept; working state is software's job
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp <= 3'h0;
      saved_pc <= 13'h0000;
    end else if (irq_accept && state == mic_pkg::MIC_VECTOR_WAIT) begin
      ret_stack[sp] <= return_pc;
      saved_pc <= return_pc;
      sp <= sp + 3'h1;
    end else if (return_from_irq) begin
      saved_pc <= ret_stack[sp - 3'h1];
      sp <= sp - 3'h1;
    end
  end

  mic_pkg::mic_state_t next_state;

  always_comb begin
    case (state)
      mic_pkg::MIC_RUN: begin
        if (global_irq_enable && any_pend) begin
          next_state = mic_pkg::MIC_VECTOR_WAIT;
        end else if (sleep_exec && !any_pend) begin
          next_state = mic_pkg::MIC_SLEEP;
        end else begin
          next_state = mic_pkg::MIC_RUN;
        end
      end
      mic_pkg::MIC_SLEEP: begin
        if (any_pend) begin
          next_state = global_irq_enable ? mic_pkg::MIC_VECTOR_WAIT : mic_pkg::MIC_RUN;
        end else begin
          next_state = mic_pkg::MIC_SLEEP;
        end
      end
      mic_pkg::MIC_VECTOR_WAIT: begin
        if (irq_accept) begin
          next_state = mic_pkg::MIC_RUN;
        end else if (!global_irq_enable) begin
          next_state = mic_pkg::MIC_RUN;
        end else begin
          next_state = mic_pkg::MIC_VECTOR_WAIT;
        end
      end
      default: next_state = mic_pkg::MIC_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= mic_pkg::MIC_RUN;
      core_req <= '0;
    end else begin
      state <= next_state;
      core_req.vector_req <= (next_state == mic_pkg::MIC_VECTOR_WAIT) & ~irq_accept;
      core_req.wake <= (state == mic_pkg::MIC_SLEEP) & any_pend;
      core_req.vector_addr <= `MIC_VECTOR;
    end
  end

  assign sleeping = (state == mic_pkg::MIC_SLEEP);

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  wire logic [31:0] rd_value =
    (s_axi_araddr == `MIC_OFF_CTRL) ? {24'h000000, interrupt_control_reg} :
    (s_axi_araddr == `MIC_OFF_OPTION) ? {24'h000000, option_reg} :
    (s_axi_araddr == `MIC_OFF_PFLAG1) ? {24'h000000, periph_flag_reg_one} :
    (s_axi_araddr == `MIC_OFF_PEN1) ? {24'h000000, periph_enable_reg_one} :
    (s_axi_araddr == `MIC_OFF_CORE) ? {13'h0000, saved_pc, sp, sleeping, state}
    : 32'h0000_0000;
  wire logic rd_known = (s_axi_araddr == `MIC_OFF_CTRL) | (s_axi_araddr == `MIC_OFF_OPTION)
                      | (s_axi_araddr == `MIC_OFF_PFLAG1) | (s_axi_araddr == `MIC_OFF_PEN1)
                      | (s_axi_araddr == `MIC_OFF_CORE);

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_known ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Unmapped writes are dropped but still answered OKAY
  wire logic unused_wr = wr_known;

endmodule

// File: mic_irq_ctrl_tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
`include "mic_regs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module mic_irq_ctrl_tb;
  typedef struct packed {
    logic [1:0] src;
    logic [7:0] ctrl;
    logic [7:0] exp;
    logic acc;
  } mic_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, sleep_exec, ret_req, ext_irq_pin, adc_done;
  logic irq_accept, return_from_irq, sleeping;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, lag;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] second_io_port, timer_zero_count, n_acc, n0;
  logic [12:0] return_pc, saved_pc, taken_pc;
  mic_pkg::mic_core_req_t core_req;
  int miscompares, n_compared, cyc, n;
  mic_row_t rows [7] = '{'{2'd0, 8'h90, 8'h12, 1'b1}, '{2'd0, 8'h80, 8'h82, 1'b0},
    '{2'd1, 8'ha0, 8'h24, 1'b1}, '{2'd1, 8'h00, 8'h04, 1'b0}, '{2'd2, 8'h88, 8'h09, 1'b1},
    '{2'd2, 8'h08, 8'h09, 1'b0}, '{2'd3, 8'hc0, 8'h40, 1'b1}};
  logic [11:0] ra [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h014};
  logic [7:0] rv [5] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  mic_irq_ctrl u_dut (.*);
  mic_core_model u_core (.aclk(aclk), .aresetn(aresetn), .core_req(core_req),
    .irq_accept(irq_accept), .return_from_irq(return_from_irq), .return_pc(return_pc),
    .lag(lag), .ret_req(ret_req), .taken_pc(taken_pc), .n_acc(n_acc));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic fire(input logic [1:0] s);
    case (s)
      2'd0: begin
        ext_irq_pin <= 1'b0;
        repeat (3) @(posedge aclk);
        ext_irq_pin <= 1'b1;
      end
      2'd1: begin
        timer_zero_count <= 8'hff;
        @(posedge aclk);
        timer_zero_count <= 8'h00;
      end
      2'd2: second_io_port[4] <= ~second_io_port[4];
      default: begin
        adc_done <= 1'b1;
        @(posedge aclk);
        adc_done <= 1'b0;
      end
    endcase
    @(posedge aclk);
  endtask
  task automatic ret();
    ret_req <= 1'b1;
    @(posedge aclk);
    ret_req <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  initial begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, ext_irq_pin, adc_done, sleep_exec} = '0;
    {ret_req, lag, second_io_port, timer_zero_count} = '0;
    s_axi_wstrb = 4'h1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      `CHK(d, {24'h0, rv[i]})
      `CHK(r, (i == 4) ? 2'h2 : 2'h0)
    end
    wr(`MIC_OFF_PEN1, 32'h1);
    for (int i = 0; i < 7; i++) begin
      wr(`MIC_OFF_PFLAG1, 32'h0);
      wr(`MIC_OFF_CTRL, {24'h0, rows[i].ctrl});
      n0 = n_acc;
      fire(rows[i].src);
      repeat (6) @(posedge aclk);
      rd(`MIC_OFF_CTRL);
      `CHK(d[7:0], rows[i].exp)
      `CHK(n_acc - n0, {7'h0, rows[i].acc})
      rd(`MIC_OFF_PFLAG1);
      `CHK(d[0], rows[i].src == 2'd3)
      if (rows[i].acc) begin
        // Flags cleared first, else the return re-enters at once
        wr(`MIC_OFF_CTRL, 32'h0);
        ret();
        `CHK(saved_pc, taken_pc)
      end
    end
    wr(`MIC_OFF_CTRL, 32'h90);
    lag <= 4'd5;
    fire(2'd1);
    ext_irq_pin <= 1'b0;
    repeat (3) @(posedge aclk);
    ext_irq_pin <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (!core_req.vector_req && n < 20);
    `CHK(n inside {3, 4}, 1'b1)
    n0 = n_acc;
    repeat (4) @(posedge aclk);
    `CHK(core_req.vector_req, 1'b1)
    repeat (4) @(posedge aclk);
    `CHK(n_acc - n0, 8'h1)
    wr(`MIC_OFF_CTRL, 32'h0);
    rd(`MIC_OFF_CTRL);
    `CHK(d[7], 1'b0)
    ret();
    lag <= 4'd0;
    for (int g = 0; g < 2; g++) begin
      wr(`MIC_OFF_CTRL, g ? 32'h90 : 32'h10);
      n0 = n_acc;
      sleep_exec <= 1'b1;
      @(posedge aclk);
      sleep_exec <= 1'b0;
      repeat (2) @(posedge aclk);
      `CHK(sleeping, 1'b1)
      fire(2'd0);
      repeat (6) @(posedge aclk);
      `CHK(sleeping, 1'b0)
      `CHK(n_acc - n0, {7'h0, g[0]})
      rd(`MIC_OFF_CTRL);
      `CHK(d[7:0], 8'h12)
    end
    wr(`MIC_OFF_OPTION, 32'h0);
    wr(`MIC_OFF_CTRL, 32'h0);
    ext_irq_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(`MIC_OFF_CTRL);
    `CHK(d[7:0], 8'h02)
    finish_test();
  end
endmodule

// File: mic_pkg.sv
// Types shared by the interrupt controller files
package mic_pkg;

  typedef struct packed {
    logic ext_pin;
    logic tmr_ovf;
    logic port_chg;
    logic adc_done;
  } mic_events_t;

  typedef struct packed {
    logic vector_req;
    logic wake;
    logic [12:0] vector_addr;
  } mic_core_req_t;

  typedef enum logic [1:0] {
    MIC_RUN,
    MIC_SLEEP,
    MIC_VECTOR_WAIT
  } mic_state_t;

endpackage

// File: mic_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define MIC_OFF_CTRL 12'h000
`define MIC_OFF_OPTION 12'h004
`define MIC_OFF_PFLAG1 12'h008
`define MIC_OFF_PEN1 12'h00c
`define MIC_OFF_CORE 12'h010

// ****************************************
// Control, option and peripheral flag register bits
// ****************************************
`define MIC_BIT_GIE 7
`define MIC_BIT_PEIE 6
`define MIC_BIT_TIMER_OVERFLOW_ENABLE 5
`define MIC_BIT_EXT_PIN_ENABLE 4
`define MIC_BIT_PORT_CHANGE_ENABLE 3
`define MIC_BIT_TIMER_OVERFLOW_FLAG 2
`define MIC_BIT_EXT_PIN_FLAG 1
`define MIC_BIT_PORT_CHANGE_FLAG 0
`define MIC_BIT_EDGE 6
`define MIC_BIT_ADIF 0

// ****************************************
// Reset values and constants
// ****************************************
`define MIC_RST_CTRL 8'h00
`define MIC_RST_OPTION 8'hff
`define MIC_RST_PERIPH 8'h00
`define MIC_VECTOR 13'h0004
`define MIC_SYNC_CYCLES 2

`endif
